/* bench/drl_port_model.sv */
// Purpose: ingress port model issuing one frame descriptor per call
// Assumes: fields change just after a rising edge, held one cycle
// Notes: idle dscp, class dscp and header word fields flip so a stale value is never trusted
`timescale 1ns/1ps
module drl_port_model
	import drl_pkg::*;
(
	input wire logic pclk,
	output logic in_valid,
	output logic [1:0] in_igr_port,
	output logic [1:0] in_egr_port,
	output logic in_is_ip,
	output logic in_is_ipv4,
	output logic [CPW-1:0] in_dscp,
	output logic [QW-1:0] in_qos,
	output logic [DW-1:0] in_dp,
	output logic in_cls_hit,
	output logic in_cls_ovr,
	output logic [CPW-1:0] in_cls_dscp,
	output logic [15:0] in_hdr_word,
	output logic [15:0] in_csum
);
	initial
	begin
		{in_valid, in_igr_port, in_egr_port, in_is_ip, in_is_ipv4} = '0;
		{in_dscp, in_qos, in_dp, in_cls_hit, in_cls_ovr, in_cls_dscp} = '0;
		{in_hdr_word, in_csum} = '0;
	end
	task send(input logic [1:0] ig, eg, input logic ip, v4, input logic [5:0] cp,
		input logic [3:0] qd, input logic hit, ovr, input logic [5:0] ccp,
		input logic [15:0] hw, cs);
		@(posedge pclk);
		in_valid <= 1'b1;
		in_igr_port <= ig;
		in_egr_port <= eg;
		in_is_ip <= ip;
		in_is_ipv4 <= v4;
		in_dscp <= cp;
		in_dp <= qd[3];
		in_qos <= qd[2:0];
		in_cls_hit <= hit;
		in_cls_ovr <= ovr;
		in_cls_dscp <= ccp;
		in_hdr_word <= hw;
		in_csum <= cs;
		@(posedge pclk);
		in_valid <= 1'b0;
		in_dscp <= ~cp;
		in_cls_dscp <= ~ccp;
		in_hdr_word <= ~hw;
	endtask : send
endmodule : drl_port_model

/* bench/testbench.sv */
// Purpose: self-checking bench for the code point remark block
// Assumes: apb master tasks, port model drives descriptors
// Notes: expected values from mode, table and enable settings
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic in_valid, in_is_ip, in_is_ipv4, in_dp, in_cls_hit, in_cls_ovr;
	logic [1:0] in_igr_port, in_egr_port;
	logic [5:0] in_dscp, in_cls_dscp;
	logic [2:0] in_qos;
	logic [15:0] in_hdr_word, in_csum, out_hdr_word, out_csum;
	logic out_valid, out_write;
	int miscompares, compares, nwr;
	drl_remark drl_remark_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .in_valid, .in_igr_port, .in_egr_port, .in_is_ip,
		.in_is_ipv4, .in_dscp, .in_qos, .in_dp, .in_cls_hit, .in_cls_ovr, .in_cls_dscp,
		.in_hdr_word, .in_csum, .out_valid, .out_write, .out_hdr_word, .out_csum);
	drl_port_model drl_port_model_inst (.pclk, .in_valid, .in_igr_port, .in_egr_port,
		.in_is_ip, .in_is_ipv4, .in_dscp, .in_qos, .in_dp, .in_cls_hit, .in_cls_ovr,
		.in_cls_dscp, .in_hdr_word, .in_csum);
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task tally_and_finish;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			miscompares++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		check(rd, e);
		check({31'h0, err}, {31'h0, ee});
	endtask : rdc
	// incremental update, so a design recomputing the whole header must agree
	function automatic logic [15:0] upd(input logic [15:0] hc, m, mn);
		logic [16:0] s;
		s = {1'b0, ~hc} + {1'b0, ~m};
		s = {1'b0, s[15:0]} + {16'h0, s[16]};
		s = {1'b0, s[15:0]} + {1'b0, mn};
		s = {1'b0, s[15:0]} + {16'h0, s[16]};
		return ~s[15:0];
	endfunction : upd
	task fr(input logic [1:0] ig, eg, input logic ip, v4, input logic [5:0] cp,
		input logic [3:0] qd, input logic hit, ovr, input logic [5:0] ccp,
		input logic ew, input logic [5:0] ecp);
		logic [15:0] hw, nw;
		hw = {8'h45, cp, 2'h1};
		nw = ew ? {8'h45, ecp, 2'h1} : hw;
		nwr += ew;
		drl_port_model_inst.send(ig, eg, ip, v4, cp, qd, hit, ovr, ccp, hw, 16'hb1e6);
		@(posedge pclk);
		#1;
		check({30'h0, out_valid, out_write}, {30'h0, 1'b1, ew});
		check({16'h0, out_hdr_word}, {16'h0, nw});
		check({16'h0, out_csum}, {16'h0, (ew && v4) ? upd(16'hb1e6, hw, nw) : 16'hb1e6});
	endtask : fr
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		miscompares = 0;
		compares = 0;
		nwr = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h000, 32'h0, 1'b0);
		rdc(12'h004, 32'h0, 1'b0);
		rdc(12'h010, 32'h0, 1'b1);
		apb(1'b1, 12'h22c, 32'h2a);
		apb(1'b1, 12'h200, 32'h11);
		apb(1'b1, 12'h114, 32'h1);
		apb(1'b1, 12'h004, 32'hd);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, 12'h000, 32'(m) << 4);
			fr(2, 0, 1, 1, 6'h00, 4'hb, 0, 0, 0, m[0], 6'h2a);
			fr(2, 3, 1, 1, 6'h05, 4'hb, 0, 0, 0, m[1], 6'h2a);
			fr(2, 2, 1, 1, 6'h09, 4'hb, 0, 0, 0, m == 3, 6'h2a);
		end
		fr(2, 0, 1, 1, 6'h09, 4'h0, 0, 0, 0, 1, 6'h11);
		fr(0, 0, 1, 1, 6'h00, 4'hb, 0, 0, 0, 0, 6'h00);
		fr(0, 2, 1, 1, 6'h00, 4'hb, 1, 0, 6'h07, 0, 6'h00);
		fr(0, 2, 1, 1, 6'h09, 4'hb, 1, 1, 6'h07, 1, 6'h07);
		fr(2, 1, 1, 1, 6'h09, 4'hb, 0, 0, 0, 0, 6'h00);
		fr(2, 0, 0, 0, 6'h09, 4'hb, 0, 0, 0, 0, 6'h00);
		fr(2, 0, 1, 0, 6'h3f, 4'hb, 0, 0, 0, 1, 6'h2a);
		apb(1'b1, 12'h1a8, 32'h1500);
		apb(1'b1, 12'h008, 32'h1);
		rdc(12'h1a8, 32'h00001500, 1'b0);
		rdc(12'h22c, 32'h0000002a, 1'b0);
		rdc(12'h008, 32'h00000001, 1'b0);
		fr(2, 3, 1, 1, 6'h09, 4'hb, 0, 0, 0, 1, 6'h15);
		fr(0, 3, 1, 1, 6'h01, 4'hb, 1, 1, 6'h2a, 1, 6'h15);
		rdc(12'h00c, 32'(nwr), 1'b0);
		tally_and_finish();
	end
endmodule : testbench

/* hw/drl_pkg.sv */
// Purpose: constants for the code point remark block
// Assumes: apb slave with 32-bit data, four switch ports
// Notes: table bases are word aligned windows
package drl_pkg;
	localparam int NPORT = 4;
	localparam int PW = 2;
	localparam int CPW = 6;
	localparam int QW = 3;
	localparam int DW = 1;
	localparam int MW = 2;
	localparam int NCP = 64;
	localparam int NMAP = 16;
	localparam int CNTW = 16;
	localparam logic [11:0] OFF_POLICY = 12'h000;
	localparam logic [11:0] OFF_EGR_ENA = 12'h004;
	localparam logic [11:0] OFF_REMAP_ENA = 12'h008;
	localparam logic [11:0] OFF_COUNT = 12'h00c;
	localparam logic [11:0] OFF_CP_BASE = 12'h100;
	localparam logic [11:0] OFF_MAP_BASE = 12'h200;
	localparam logic [11:0] OFF_MAP_END = 12'h240;
	localparam logic [11:0] OFF_CP_END = 12'h200;
	localparam int CP_ENA_BIT = 0;
	localparam int CP_REMAP_LSB = 8;
	localparam int TOS_DSCP_LSB = 2;
	localparam logic [MW-1:0] MODE_OFF = 2'h0;
	localparam logic [MW-1:0] MODE_ZERO = 2'h1;
	localparam logic [MW-1:0] MODE_SEL = 2'h2;
	localparam logic [MW-1:0] MODE_ALL = 2'h3;
	localparam logic [NPORT*MW-1:0] RST_POLICY = 8'h00;
	localparam logic [NPORT-1:0] RST_EGR_ENA = 4'h0;
	localparam logic [CPW-1:0] RST_CP = 6'h00;
endpackage : drl_pkg

/* hw/drl_remark.sv */
// Purpose: per frame code point remark decision and egress rewrite
// Assumes: one frame descriptor per cycle at most, apb register access
// Notes: two stage pipe, ingress decision then egress write
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
//Contract
//[RQ1] The code point is handled as a six-bit field.
//[RQ2] Each ingress port has its own two-bit remark mode.
//[RQ3] Mode 0x0 never changes the received code point. The code still remarks a frame with a classifier hit and override flag.
//[RQ4] Mode 0x1 selects a frame only when its code point is zero.
//[RQ5] Mode 0x2 selects a frame only when its code point's enable bit is set.
//[RQ6] Mode 0x3 selects every frame from the port.
//[RQ7] A selected frame gets its new value from a table indexed by drop level and class.
//[RQ8] A classifier hit with the override flag replaces the table value.
//[RQ9] Decision and value are made at ingress and carried to the egress stage.
//[RQ10] Egress writes the value only if that egress port's rewrite enable is set.
//[RQ11] Egress may translate the value through a global remap table first.
//[RQ12] Any IPv4 code point change updates the header checksum.
//[RQ13] Table and override values get the same egress enable and remap handling.
//[RQ14] Frames with no IP header pass without any change.
module drl_remark
	import drl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	input wire logic [1:0] in_igr_port,
	input wire logic [1:0] in_egr_port,
	input wire logic in_is_ip,
	input wire logic in_is_ipv4,
	input wire logic [CPW-1:0] in_dscp,
	input wire logic [QW-1:0] in_qos,
	input wire logic [DW-1:0] in_dp,
	input wire logic in_cls_hit,
	input wire logic in_cls_ovr,
	input wire logic [CPW-1:0] in_cls_dscp,
	input wire logic [15:0] in_hdr_word,
	input wire logic [15:0] in_csum,
	output logic out_valid,
	output logic out_write,
	output logic [15:0] out_hdr_word,
	output logic [15:0] out_csum
);
	function automatic logic [15:0] drl_oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : drl_oc_add

	logic [NPORT*MW-1:0] policy_r;
	logic [NPORT-1:0] egr_ena_r;
	logic remap_ena_r;
	logic [CNTW-1:0] count_r;
	logic cp_ena_r [NCP];
	logic [CPW-1:0] remap_r [NCP];
	logic [CPW-1:0] map_r [NMAP];
	logic a_valid_r;
	logic a_remark_r;
	logic [CPW-1:0] a_val_r;
	logic [1:0] a_port_r;
	logic a_ipv4_r;
	logic [15:0] a_hdr_r;
	logic [15:0] a_csum_r;

	// apb decode
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready & pwrite;
	wire [11:0] cp_off = paddr - OFF_CP_BASE;
	wire [11:0] map_off = paddr - OFF_MAP_BASE;
	wire [5:0] cp_idx = cp_off[7:2];
	wire [3:0] map_idx = map_off[5:2];
	wire hit_pol = paddr == OFF_POLICY;
	wire hit_egr = paddr == OFF_EGR_ENA;
	wire hit_rmp = paddr == OFF_REMAP_ENA;
	wire hit_cnt = paddr == OFF_COUNT;
	wire hit_cp = paddr >= OFF_CP_BASE && paddr < OFF_CP_END && paddr[1:0] == 2'h0;
	wire hit_map = paddr >= OFF_MAP_BASE && paddr < OFF_MAP_END && paddr[1:0] == 2'h0;
	wire hit_any = hit_pol | hit_egr | hit_rmp | hit_cnt | hit_cp | hit_map;
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (hit_pol)
			rd_mux[NPORT*MW-1:0] = policy_r;
		else if (hit_egr)
			rd_mux[NPORT-1:0] = egr_ena_r;
		else if (hit_rmp)
			rd_mux[0] = remap_ena_r;
		else if (hit_cnt)
			rd_mux[CNTW-1:0] = count_r;
		else if (hit_cp)
		begin
			rd_mux[CP_ENA_BIT] = cp_ena_r[cp_idx];
			rd_mux[CP_REMAP_LSB +: CPW] = remap_r[cp_idx];
		end
		else if (hit_map)
			rd_mux[CPW-1:0] = map_r[map_idx];
	end

	// answer one cycle after setup, so pready is a clean flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~hit_any;
			prdata <= setup ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			policy_r <= RST_POLICY;
			egr_ena_r <= RST_EGR_ENA;
			remap_ena_r <= 1'b0;
		end
		else if (wr_en)
		begin
			if (hit_pol)
				policy_r <= pwdata[NPORT*MW-1:0];
			if (hit_egr)
				egr_ena_r <= pwdata[NPORT-1:0];
			if (hit_rmp)
				remap_ena_r <= pwdata[0];
		end
	end

	// tables kept in flops; small enough to avoid a ram macro
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NCP; i++)
			begin
				cp_ena_r[i] <= 1'b0;
				remap_r[i] <= RST_CP;
			end
			for (int j = 0; j < NMAP; j++)
				map_r[j] <= RST_CP;
		end
		else if (wr_en)
		begin
			if (hit_cp)
			begin
				cp_ena_r[cp_idx] <= pwdata[CP_ENA_BIT];
				remap_r[cp_idx] <= pwdata[CP_REMAP_LSB +: CPW];
			end
			if (hit_map)
				map_r[map_idx] <= pwdata[CPW-1:0];
		end
	end

	// ingress decision
	wire [MW-1:0] mode = policy_r[in_igr_port*MW +: MW]; // [RQ2]
	wire sel_zero = mode == MODE_ZERO && in_dscp == RST_CP; // [RQ4]
	wire sel_en = mode == MODE_SEL && cp_ena_r[in_dscp]; // [RQ5]
	wire sel_all = mode == MODE_ALL; // [RQ6]
	// mode off selects nothing; non ip frames are never selected
	wire sel = in_is_ip & (sel_zero | sel_en | sel_all); // [RQ3] [RQ14]
	wire use_ovr = in_is_ip & in_cls_hit & in_cls_ovr;
	wire [CPW-1:0] tbl_val = map_r[{in_dp, in_qos}]; // [RQ7]
	wire [CPW-1:0] new_val = use_ovr ? in_cls_dscp : tbl_val; // [RQ8]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			a_valid_r <= 1'b0;
			a_remark_r <= 1'b0;
			a_val_r <= RST_CP;
			a_port_r <= 2'h0;
			a_ipv4_r <= 1'b0;
			a_hdr_r <= 16'h0000;
			a_csum_r <= 16'h0000;
		end
		else
		begin
			a_valid_r <= in_valid;
			a_remark_r <= in_valid & (sel | use_ovr); // [RQ9]
			a_val_r <= new_val; // [RQ9]
			a_port_r <= in_egr_port;
			a_ipv4_r <= in_is_ipv4 & in_is_ip;
			a_hdr_r <= in_hdr_word;
			a_csum_r <= in_csum;
		end
	end

	// egress rewrite, same path for table and override values
	wire eg_write = a_valid_r & a_remark_r & egr_ena_r[a_port_r]; // [RQ10] [RQ13]
	wire [CPW-1:0] eg_val = remap_ena_r ? remap_r[a_val_r] : a_val_r; // [RQ11] [RQ13]
	wire [15:0] new_hdr = {a_hdr_r[15:8], eg_val, a_hdr_r[TOS_DSCP_LSB-1:0]}; // [RQ1]
	// incremental update: ~(~hc + ~m + m')
	wire [15:0] csum_upd = ~drl_oc_add(drl_oc_add(~a_csum_r, ~a_hdr_r), new_hdr); // [RQ12]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid <= 1'b0;
			out_write <= 1'b0;
			out_hdr_word <= 16'h0000;
			out_csum <= 16'h0000;
			count_r <= '0;
		end
		else
		begin
			out_valid <= a_valid_r;
			out_write <= eg_write;
			out_hdr_word <= eg_write ? new_hdr : a_hdr_r;
			out_csum <= (eg_write & a_ipv4_r) ? csum_upd : a_csum_r; // [RQ12]
			if (eg_write)
				count_r <= count_r + 1'b1;
		end
	end

	property p_mode_off;
		@(posedge pclk) disable iff (!presetn)
		in_valid && mode == MODE_OFF && !use_ovr |=> !a_remark_r;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("mode off remarked"); // [RQ3]

	property p_mode_zero;
		@(posedge pclk) disable iff (!presetn)
		in_valid && mode == MODE_ZERO && in_dscp != RST_CP && !use_ovr |=> !a_remark_r;
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("nonzero selected"); // [RQ4]

	property p_mode_sel;
		@(posedge pclk) disable iff (!presetn)
		in_valid && in_is_ip && mode == MODE_SEL |=> a_remark_r == $past(cp_ena_r[in_dscp] | use_ovr);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("select mode wrong"); // [RQ5]

	property p_mode_all;
		@(posedge pclk) disable iff (!presetn)
		in_valid && in_is_ip && mode == MODE_ALL |=> a_remark_r && a_val_r == $past(new_val);
	endproperty
	a_mode_all: assert property (p_mode_all) else $error("all mode missed"); // [RQ6]

	property p_ovr;
		@(posedge pclk) disable iff (!presetn)
		in_valid && in_is_ip && in_cls_hit && in_cls_ovr |=> a_val_r == $past(in_cls_dscp);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override lost"); // [RQ8]

	property p_egr;
		@(posedge pclk) disable iff (!presetn)
		a_valid_r && !egr_ena_r[a_port_r] |=> !out_write && out_csum == $past(a_csum_r);
	endproperty
	a_egr: assert property (p_egr) else $error("disabled port written"); // [RQ10]

	property p_nonip;
		@(posedge pclk) disable iff (!presetn)
		in_valid && !in_is_ip |-> ##2 out_valid && !out_write && out_csum == $past(in_csum, 2);
	endproperty
	a_nonip: assert property (p_nonip) else $error("non ip frame changed"); // [RQ14]

	property p_remap;
		@(posedge pclk) disable iff (!presetn)
		eg_write && remap_ena_r |=> out_hdr_word[TOS_DSCP_LSB +: CPW] == $past(remap_r[a_val_r]);
	endproperty
	a_remap: assert property (p_remap) else $error("remap not applied"); // [RQ11]

	property p_csum;
		@(posedge pclk) disable iff (!presetn)
		eg_write && a_ipv4_r |=> drl_oc_add(~out_csum, ~out_hdr_word)
			== drl_oc_add(~$past(a_csum_r), ~$past(a_hdr_r));
	endproperty
	a_csum: assert property (p_csum) else $error("checksum not updated"); // [RQ12]

	property p_latency;
		@(posedge pclk) disable iff (!presetn)
		in_valid |-> ##2 out_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("result not two cycles later"); // [RQ9]

	property p_zero_sel;
		@(posedge pclk) disable iff (!presetn)
		in_valid && in_is_ip && mode == MODE_ZERO && in_dscp == RST_CP |=> a_remark_r;
	endproperty
	a_zero_sel: assert property (p_zero_sel) else $error("zero code point not selected"); // [RQ4]

	property p_direct;
		@(posedge pclk) disable iff (!presetn)
		eg_write && !remap_ena_r |=> out_hdr_word[TOS_DSCP_LSB +: CPW] == $past(a_val_r);
	endproperty
	a_direct: assert property (p_direct) else $error("forwarded value not written"); // [RQ13]

	property p_count;
		@(posedge pclk) disable iff (!presetn)
		eg_write |=> count_r == $past(count_r) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("write count not advanced"); // [RQ10]
endmodule : drl_remark
